// ===== cstc_params.svh
`ifndef CSTC_PARAMS_SVH
`define CSTC_PARAMS_SVH

`define CSTC_NUM_CH 8
`define CSTC_CH_W 3
`define CSTC_CFG_W 16
// Reset value of every channel's configuration word
`define CSTC_CFG_RESET 16'h0000
// Readable bit mask: bits 13 and 12 are held at zero
`define CSTC_CFG_MASK 16'hcfff
`define CSTC_B_MODE_HI 15
`define CSTC_B_MODE_LO 14
`define CSTC_B_FAST_SERVO_OFF 11
`define CSTC_B_SUP_RES 10
`define CSTC_B_ADC_HIRES 9
`define CSTC_B_RUN_SEL 8
`define CSTC_B_SERVO_CONT 7
`define CSTC_B_SERVO_WARN 6
`define CSTC_B_DAC_HI 5
`define CSTC_B_DAC_LO 4
`define CSTC_B_WPU 3
`define CSTC_B_WPD 2
`define CSTC_B_DAC_GAIN 1
`define CSTC_B_DAC_POL 0
// First channel whose enable pin has no weak pull options
`define CSTC_WEAK_CH_LIMIT 3'h4
// Leader fall allowance, given in ns and converted to clock cycles
`define CSTC_CLK_MHZ 200
`define CSTC_FALL_TIME_NS 1000
`define CSTC_FALL_CYC ((`CSTC_FALL_TIME_NS * `CSTC_CLK_MHZ) / 1000)

`endif

// ===== cstc_pkg.sv
package cstc_pkg;

  typedef enum logic [1:0] {
    CSTC_DAC_SERVO,
    CSTC_DAC_OPEN,
    CSTC_DAC_DIRECT,
    CSTC_DAC_SOFT_WRITE
  } cstc_dac_mode_e;

  typedef enum logic [1:0] {
    CSTC_PD_NONE,
    CSTC_PD_WEAK,
    CSTC_PD_FAST
  } cstc_pull_e;

  // Per-channel control decoded from the configuration word
  typedef struct packed {
    logic follower;
    logic seq_off_on_fault;
    logic fast_servo_en;
    logic sup_low_res;
    logic adc_hires;
    logic run_sel;
    logic servo_cont;
    logic servo_warn;
    cstc_dac_mode_e dac_mode;
    logic weak_pu;
    logic weak_pd;
    logic dac_gain_hi;
    logic dac_noninv;
  } cstc_ctrl_s;

  // Per-channel output drive
  typedef struct packed {
    logic en_drive;
    logic weak_pu;
    cstc_pull_e pull;
    logic uv_mask;
    logic dac_connect;
    logic dac_soft;
    logic servo_active;
  } cstc_chan_out_s;

endpackage

// ===== cstc_cfg_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "cstc_params.svh"

module cstc_cfg_regs
  import cstc_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic [`CSTC_CH_W-1:0] page_i,
  input wire logic wr_i,
  input wire logic [`CSTC_CFG_W-1:0] wdata_i,
  output logic [`CSTC_CFG_W-1:0] rdata_o,
  output logic [`CSTC_NUM_CH*`CSTC_CFG_W-1:0] cfg_all_o
);

  logic [`CSTC_CFG_W-1:0] cfg_reg [`CSTC_NUM_CH];

  genvar g;
  generate
    for (g = 0; g < `CSTC_NUM_CH; g++) begin : g_ch
      always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
          cfg_reg[g] <= `CSTC_CFG_RESET;
        end else if (wr_i && page_i == `CSTC_CH_W'(g)) begin // [R24]
          cfg_reg[g] <= wdata_i & `CSTC_CFG_MASK; // [R4]
        end
      end
      assign cfg_all_o[g*`CSTC_CFG_W +: `CSTC_CFG_W] = cfg_reg[g];
    end
  endgenerate

  assign rdata_o = cfg_reg[page_i]; // [R24]

endmodule // cstc_cfg_regs

`default_nettype wire

// ===== cstc_track_group.sv
`timescale 1ns/1ps
`default_nettype none
`include "cstc_params.svh"

module cstc_track_group
  import cstc_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic leader_run_i,
  input wire logic any_follower_i,
  input wire logic group_down_i,
  output logic track_en_o,
  output logic leader_go_o,
  output logic tracking_o
);

  typedef enum logic [1:0] {
    CSTC_TG_OFF, CSTC_TG_PRE, CSTC_TG_UP, CSTC_TG_FALL
  } cstc_tg_state_e;

  cstc_tg_state_e state_reg;
  logic [15:0] cnt_reg;

  // Followers are enabled before the leader ramps and released after it falls
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      state_reg <= CSTC_TG_OFF;
      cnt_reg <= 16'h0000;
    end else begin
      unique case (state_reg)
        CSTC_TG_OFF: begin
          if (leader_run_i && !group_down_i) begin
            state_reg <= CSTC_TG_PRE;
          end
        end
        CSTC_TG_PRE: begin
          if (group_down_i || !leader_run_i) begin
            state_reg <= CSTC_TG_OFF;
          end else begin
            state_reg <= CSTC_TG_UP; // [R17]
          end
        end
        CSTC_TG_UP: begin
          if (group_down_i || !leader_run_i) begin // [R19]
            state_reg <= CSTC_TG_FALL;
            cnt_reg <= 16'(`CSTC_FALL_CYC);
          end
        end
        CSTC_TG_FALL: begin
          if (cnt_reg == 16'h0000) begin
            state_reg <= CSTC_TG_OFF; // [R17]
          end else begin
            cnt_reg <= cnt_reg - 16'h0001;
          end
        end
      endcase
    end
  end

  assign track_en_o = any_follower_i && (state_reg != CSTC_TG_OFF);
  assign leader_go_o = (state_reg == CSTC_TG_UP);
  assign tracking_o = (state_reg == CSTC_TG_PRE) || (state_reg == CSTC_TG_FALL);

endmodule // cstc_track_group

`default_nettype wire

// ===== cstc_channel_seq.sv
`timescale 1ns/1ps
`default_nettype none
`include "cstc_params.svh"

// Notes on behaviour
// [R1] Mode 00: delay sequencing, immediate off on fault
// [R2] Mode 01: delay sequencing, sequenced off on fault
// [R3] Mode 1x: channel acts as tracking follower
// [R4] Bits 13:12 ignore writes, read zero
// [R5] Fast servo on when its disable bit clear
// [R6] Supervisor resolution 4 mV or 8 mV step
// [R7] ADC high resolution only on odd channels
// [R8] Run select chooses run input a or b
// [R9] Continuous servo only applies in DAC mode 00
// [R10] Re-servo on warning in mode 00, non-continuous
// [R11] DAC mode chosen after on and rise elapsed
// [R12] Host must write DAC code in mode 10
// [R13] Weak pull-up while on, channels 0-3 only
// [R14] Weak pull-down after soft stop, fast after fault
// [R15] DAC gain picks 1.38 V or 2.65 V scale
// [R16] DAC polarity picks inverting or noninverting trim
// [R17] Followers on before leader, off after it
// [R18] Follower undervoltage suppressed while tracking
// [R19] Any channel fault tracks whole group down
// [R20] Input-off, timebase low or restore track down
// [R21] Selected channels sequence around the group
// [R22] Early followers wait for tracking permission
// [R23] Tracking turns followers off despite run input
// [R24] Configuration stored per channel, selected by page

module cstc_channel_seq
  import cstc_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic [`CSTC_CH_W-1:0] page_i,
  input wire logic cfg_wr_i,
  input wire logic [`CSTC_CFG_W-1:0] cfg_wdata_i,
  output logic [`CSTC_CFG_W-1:0] cfg_rdata_o,
  input wire logic run_input_a_i,
  input wire logic run_input_b_i,
  input wire logic [`CSTC_NUM_CH-1:0] chan_fault_i,
  input wire logic [`CSTC_NUM_CH-1:0] rise_done_i,
  input wire logic [`CSTC_NUM_CH-1:0] off_seq_done_i,
  input wire logic [`CSTC_NUM_CH-1:0] target_reached_i,
  input wire logic [`CSTC_NUM_CH-1:0] vout_warn_i,
  input wire logic [`CSTC_NUM_CH-1:0] seq_outside_i,
  input wire logic input_sense_pin_below_off_i,
  input wire logic timebase_low_i,
  input wire logic restore_i,
  input wire logic [`CSTC_NUM_CH-1:0] dac_code_written_i,
  output logic [`CSTC_NUM_CH-1:0] enable_o,
  output logic [`CSTC_NUM_CH-1:0] enable_oe_o,
  output logic [`CSTC_NUM_CH-1:0] enable_pin_weak_pullup_o,
  output logic [`CSTC_NUM_CH-1:0] enable_pin_weak_pulldown_o,
  output logic [`CSTC_NUM_CH-1:0] fast_pulldown_o,
  output logic [`CSTC_NUM_CH-1:0] uv_mask_o,
  output logic [`CSTC_NUM_CH-1:0] dac_connect_o,
  output logic [`CSTC_NUM_CH-1:0] dac_soft_connect_o,
  output logic [`CSTC_NUM_CH-1:0] dac_write_allow_o,
  output logic [`CSTC_NUM_CH-1:0] servo_active_o,
  output logic [`CSTC_NUM_CH-1:0] fast_servo_o,
  output logic [`CSTC_NUM_CH-1:0] sup_low_res_o,
  output logic [`CSTC_NUM_CH-1:0] adc_hires_o,
  output logic [`CSTC_NUM_CH-1:0] dac_gain_hi_o,
  output logic [`CSTC_NUM_CH-1:0] dac_noninv_o,
  output logic [`CSTC_NUM_CH-1:0] track_en_o
);

  function automatic cstc_ctrl_s decode_cfg(input logic [`CSTC_CFG_W-1:0] w,
                                            input logic [`CSTC_CH_W-1:0] ch);
    cstc_ctrl_s c;
    c.follower = w[`CSTC_B_MODE_HI]; // [R3]
    c.seq_off_on_fault = !w[`CSTC_B_MODE_HI] && w[`CSTC_B_MODE_LO]; // [R1] [R2]
    c.fast_servo_en = !w[`CSTC_B_FAST_SERVO_OFF]; // [R5]
    c.sup_low_res = w[`CSTC_B_SUP_RES]; // [R6]
    c.adc_hires = w[`CSTC_B_ADC_HIRES] && ch[0]; // [R7]
    c.run_sel = w[`CSTC_B_RUN_SEL]; // [R8]
    c.servo_cont = w[`CSTC_B_SERVO_CONT];
    c.servo_warn = w[`CSTC_B_SERVO_WARN];
    c.dac_mode = cstc_dac_mode_e'(w[`CSTC_B_DAC_HI:`CSTC_B_DAC_LO]);
    c.weak_pu = w[`CSTC_B_WPU] && (ch < `CSTC_WEAK_CH_LIMIT); // [R13]
    c.weak_pd = w[`CSTC_B_WPD] && (ch < `CSTC_WEAK_CH_LIMIT); // [R14]
    c.dac_gain_hi = w[`CSTC_B_DAC_GAIN]; // [R15]
    c.dac_noninv = w[`CSTC_B_DAC_POL]; // [R16]
    return c;
  endfunction

  logic [`CSTC_NUM_CH*`CSTC_CFG_W-1:0] cfg_all;
  logic [`CSTC_CFG_W-1:0] rdata;

  cstc_cfg_regs u_regs (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .page_i(page_i),
    .wr_i(cfg_wr_i),
    .wdata_i(cfg_wdata_i),
    .rdata_o(rdata),
    .cfg_all_o(cfg_all)
  );

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      cfg_rdata_o <= `CSTC_CFG_RESET;
    end else begin
      cfg_rdata_o <= rdata & `CSTC_CFG_MASK; // [R4]
    end
  end

  cstc_ctrl_s ctrl [`CSTC_NUM_CH];
  logic [`CSTC_NUM_CH-1:0] run_req, is_follower;

  // A leader is a non-follower channel not in seq_outside_i whose run request starts the group
  logic leader_run, any_follower, group_down, track_en, leader_go, tracking;
  logic [`CSTC_NUM_CH-1:0] on_reg, fault_off_reg, stop_pend_reg;

  // Any channel fault while followers exist, or a global down cause
  assign group_down = (|(chan_fault_i & (is_follower | ~is_follower)) && any_follower) // [R19]
    || input_sense_pin_below_off_i || timebase_low_i || restore_i; // [R20]
  assign any_follower = |is_follower;
  assign leader_run = |(run_req & ~is_follower & ~seq_outside_i);

  cstc_track_group u_group (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .leader_run_i(leader_run),
    .any_follower_i(any_follower),
    .group_down_i(group_down),
    .track_en_o(track_en),
    .leader_go_o(leader_go),
    .tracking_o(tracking)
  );

  genvar g;
  generate
    for (g = 0; g < `CSTC_NUM_CH; g++) begin : g_ch
      logic dac_live, servo_live;
      assign ctrl[g] = decode_cfg(cfg_all[g*`CSTC_CFG_W +: `CSTC_CFG_W],
                                  `CSTC_CH_W'(g));
      assign is_follower[g] = ctrl[g].follower;
      assign run_req[g] = ctrl[g].run_sel ? run_input_b_i : run_input_a_i; // [R8]

      // On/off state per channel
      always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
          on_reg[g] <= 1'b0;
          fault_off_reg[g] <= 1'b0;
          stop_pend_reg[g] <= 1'b0;
        end else if (ctrl[g].follower) begin
          // Run input only arms the follower; tracking gates it
          on_reg[g] <= run_req[g] && track_en; // [R22] [R23]
          stop_pend_reg[g] <= 1'b0;
          if (on_reg[g] && !track_en) begin
            fault_off_reg[g] <= group_down;
          end else if (run_req[g] && track_en) begin
            fault_off_reg[g] <= 1'b0;
          end
        end else if (chan_fault_i[g] || (any_follower && group_down && on_reg[g])) begin
          if (ctrl[g].seq_off_on_fault || seq_outside_i[g]) begin // [R2] [R21]
            stop_pend_reg[g] <= on_reg[g];
          end else begin
            on_reg[g] <= 1'b0; // [R1]
          end
          fault_off_reg[g] <= 1'b1;
        end else if (stop_pend_reg[g]) begin
          if (off_seq_done_i[g]) begin // [R2]
            on_reg[g] <= 1'b0;
            stop_pend_reg[g] <= 1'b0;
          end
        end else if (seq_outside_i[g] && any_follower) begin
          // Sequences up after group is up, down before group drops
          on_reg[g] <= run_req[g] && leader_go && !tracking; // [R21]
          if (run_req[g]) begin
            fault_off_reg[g] <= 1'b0;
          end
        end else begin
          // With followers present the leader waits until they are enabled
          on_reg[g] <= run_req[g] && (leader_go || !any_follower); // [R17]
          if (run_req[g]) begin
            fault_off_reg[g] <= 1'b0;
          end
        end
      end

      // DAC connect and servo only after the channel is on and rise elapsed
      assign dac_live = on_reg[g] && rise_done_i[g]; // [R11]
      // Direct mode waits for a code write since the code is undefined
      assign servo_live = dac_live && ctrl[g].dac_mode == CSTC_DAC_SERVO &&
        (ctrl[g].servo_cont || !target_reached_i[g] || // [R9]
         (ctrl[g].servo_warn && vout_warn_i[g])); // [R10]

      always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
          enable_o[g] <= 1'b0;
          enable_oe_o[g] <= 1'b1;
          enable_pin_weak_pullup_o[g] <= 1'b0;
          enable_pin_weak_pulldown_o[g] <= 1'b0;
          fast_pulldown_o[g] <= 1'b1;
          uv_mask_o[g] <= 1'b0;
          dac_connect_o[g] <= 1'b0;
          dac_soft_connect_o[g] <= 1'b0;
          dac_write_allow_o[g] <= 1'b0;
          servo_active_o[g] <= 1'b0;
          fast_servo_o[g] <= 1'b0;
          sup_low_res_o[g] <= 1'b0;
          adc_hires_o[g] <= 1'b0;
          dac_gain_hi_o[g] <= 1'b0;
          dac_noninv_o[g] <= 1'b0;
        end else begin
          enable_o[g] <= on_reg[g];
          // Weak pull-up drives only when on; when off the pin is driven low instead
          enable_pin_weak_pullup_o[g] <= on_reg[g] && ctrl[g].weak_pu; // [R13]
          // Pin is only driven low while off; when on it is released
          enable_oe_o[g] <= !on_reg[g]; // [R13]
          enable_pin_weak_pulldown_o[g] <= !on_reg[g] && ctrl[g].weak_pd &&
            !fault_off_reg[g]; // [R14]
          fast_pulldown_o[g] <= !on_reg[g] && (!ctrl[g].weak_pd || fault_off_reg[g]); // [R14]
          uv_mask_o[g] <= ctrl[g].follower && (tracking || !track_en); // [R18]
          unique case (ctrl[g].dac_mode) // [R11]
            CSTC_DAC_SERVO: begin
              dac_connect_o[g] <= dac_live;
              dac_soft_connect_o[g] <= dac_live;
              dac_write_allow_o[g] <= 1'b0;
            end
            CSTC_DAC_OPEN: begin
              dac_connect_o[g] <= 1'b0;
              dac_soft_connect_o[g] <= 1'b0;
              dac_write_allow_o[g] <= 1'b0;
            end
            CSTC_DAC_DIRECT: begin
              dac_connect_o[g] <= dac_live && dac_code_written_i[g]; // [R12]
              dac_soft_connect_o[g] <= 1'b0;
              dac_write_allow_o[g] <= 1'b1;
            end
            CSTC_DAC_SOFT_WRITE: begin
              dac_connect_o[g] <= dac_live;
              dac_soft_connect_o[g] <= dac_live;
              dac_write_allow_o[g] <= dac_live && target_reached_i[g];
            end
          endcase
          servo_active_o[g] <= servo_live;
          fast_servo_o[g] <= servo_live && ctrl[g].fast_servo_en; // [R5]
          sup_low_res_o[g] <= ctrl[g].sup_low_res; // [R6]
          adc_hires_o[g] <= ctrl[g].adc_hires; // [R7]
          dac_gain_hi_o[g] <= ctrl[g].dac_gain_hi; // [R15]
          dac_noninv_o[g] <= ctrl[g].dac_noninv; // [R16]
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      track_en_o <= '0;
    end else begin
      track_en_o <= {`CSTC_NUM_CH{track_en}} & is_follower; // [R17]
    end
  end

endmodule // cstc_channel_seq

`default_nettype wire

// ===== cstc_channel_seq_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "cstc_params.svh"
module cstc_channel_seq_props
  import cstc_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic [`CSTC_CH_W-1:0] page_i,
  input wire logic cfg_wr_i,
  input wire logic [`CSTC_CFG_W-1:0] cfg_wdata_i,
  input wire logic [`CSTC_CFG_W-1:0] cfg_rdata_o,
  input wire logic [`CSTC_NUM_CH-1:0] adc_hires_o,
  input wire logic [`CSTC_NUM_CH-1:0] enable_pin_weak_pullup_o,
  input wire logic [`CSTC_NUM_CH-1:0] enable_pin_weak_pulldown_o,
  input wire logic [`CSTC_NUM_CH-1:0] sup_low_res_o,
  input wire logic [`CSTC_NUM_CH-1:0] dac_gain_hi_o,
  input wire logic [`CSTC_NUM_CH-1:0] dac_noninv_o,
  input wire logic [`CSTC_NUM_CH-1:0] enable_o,
  input wire logic [`CSTC_NUM_CH-1:0] enable_oe_o,
  input wire logic [`CSTC_NUM_CH-1:0] fast_pulldown_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (srst_i);
  a_rsvd_read_zero: assert property (cfg_rdata_o[13:12] == 2'h0)
    else $error("reserved config bits read nonzero");
  a_even_adc_low: assert property ((adc_hires_o & 8'h55) == 8'h00)
    else $error("even channel shows high ADC resolution");
  a_upper_wpu_off: assert property (enable_pin_weak_pullup_o[7:4] == 4'h0)
    else $error("weak pull-up on channel 4 to 7");
  a_upper_wpd_off: assert property (enable_pin_weak_pulldown_o[7:4] == 4'h0)
    else $error("weak pull-down on channel 4 to 7");
  // Page must stay put for the cycle after the write so the read shows it
  a_cfg_readback: assert property (cfg_wr_i ##1 $stable(page_i) |->
    ##1 cfg_rdata_o == ($past(cfg_wdata_i, 2) & `CSTC_CFG_MASK))
    else $error("config readback differs from write");
  a_sup_res_cfg: assert property (cfg_wr_i |->
    ##2 sup_low_res_o[$past(page_i, 2)] == $past(cfg_wdata_i[10], 2))
    else $error("supervisor resolution not taken from config");
  a_dac_gain_cfg: assert property (cfg_wr_i |->
    ##2 dac_gain_hi_o[$past(page_i, 2)] == $past(cfg_wdata_i[1], 2))
    else $error("DAC gain not taken from config");
  a_dac_pol_cfg: assert property (cfg_wr_i |->
    ##2 dac_noninv_o[$past(page_i, 2)] == $past(cfg_wdata_i[0], 2))
    else $error("DAC polarity not taken from config");
  a_odd_adc_cfg: assert property (cfg_wr_i && page_i[0] |->
    ##2 adc_hires_o[$past(page_i, 2)] == $past(cfg_wdata_i[9], 2))
    else $error("odd channel ADC resolution not taken from config");
  a_oe_released_on: assert property ((enable_oe_o & enable_o) == 8'h00)
    else $error("enable pin driven while channel on");
  a_pull_one_kind: assert property ((enable_pin_weak_pulldown_o & fast_pulldown_o) == 8'h00)
    else $error("weak and fast pull-down both active");
  a_fast_pd_off: assert property ((fast_pulldown_o & enable_o) == 8'h00)
    else $error("fast pull-down active while channel on");
endmodule // cstc_channel_seq_props
bind cstc_channel_seq cstc_channel_seq_props i_cstc_channel_seq_props (.sys_clk_i, .srst_i,
  .page_i, .cfg_wr_i, .cfg_wdata_i, .cfg_rdata_o, .adc_hires_o, .enable_pin_weak_pullup_o,
  .enable_pin_weak_pulldown_o, .sup_low_res_o, .dac_gain_hi_o, .dac_noninv_o, .enable_o,
  .enable_oe_o, .fast_pulldown_o);
`default_nettype wire

// ===== cstc_dcdc_model.sv
`timescale 1ns/1ps
`default_nettype none
module cstc_dcdc_model
  import cstc_pkg::*;
#(
  parameter int RISE_CYC = 8
)
(
  input wire logic sys_clk_i,
  input wire logic [7:0] enable_i,
  input wire logic [7:0] dac_connect_i,
  output logic [7:0] rise_done_o,
  output logic [7:0] off_seq_done_o,
  output logic [7:0] target_reached_o
);
  int cnt [8];
  // Converter ramps for a fixed time; off sequence ends once the ramp count is back at zero
  always_ff @(posedge sys_clk_i) begin
    for (int i = 0; i < 8; i++) begin
      cnt[i] <= !enable_i[i] ? 0 : (cnt[i] == RISE_CYC) ? cnt[i] : cnt[i] + 1;
      rise_done_o[i] <= enable_i[i] && (cnt[i] == RISE_CYC);
      off_seq_done_o[i] <= !enable_i[i] && (cnt[i] == 0);
      target_reached_o[i] <= dac_connect_i[i] && rise_done_o[i];
    end
  end
endmodule // cstc_dcdc_model
`default_nettype wire

// ===== cstc_channel_seq_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "cstc_params.svh"
module cstc_channel_seq_tb;
  import cstc_pkg::*;
  logic sys_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [2:0] page_i = 3'h0;
  logic cfg_wr_i = 1'b0;
  logic [15:0] cfg_wdata_i = 16'h0000;
  logic run_input_a_i = 1'b0;
  logic run_input_b_i = 1'b0;
  logic [7:0] chan_fault_i = 8'h00;
  logic [7:0] dac_code_written_i = 8'h00;
  logic timebase_low_i = 1'b0;
  logic [7:0] servo_o, trk;
  logic [7:0] rise_done_i, off_seq_done_i, target_reached_i;
  logic [15:0] cfg_rdata_o;
  logic [7:0] enable_o, enable_oe_o, wpu, wpd, fast_pulldown_o, uv_mask_o, dac_connect_o;
  logic [7:0] sup_low_res_o, adc_hires_o, dac_gain_hi_o, dac_noninv_o;
  logic [15:0] rd_val;
  int miscompares = 0;
  int total_checks = 0;
  int cycles = 0;
  cstc_channel_seq i_cstc_channel_seq (.sys_clk_i, .srst_i, .page_i, .cfg_wr_i, .cfg_wdata_i,
    .cfg_rdata_o, .run_input_a_i, .run_input_b_i, .chan_fault_i, .rise_done_i, .off_seq_done_i,
    .target_reached_i, .vout_warn_i(8'h00), .seq_outside_i(8'h00),
    .input_sense_pin_below_off_i(1'b0), .timebase_low_i, .restore_i(1'b0),
    .dac_code_written_i, .enable_o, .enable_oe_o, .enable_pin_weak_pullup_o(wpu),
    .enable_pin_weak_pulldown_o(wpd), .fast_pulldown_o, .uv_mask_o, .dac_connect_o,
    .dac_soft_connect_o(), .dac_write_allow_o(), .servo_active_o(servo_o), .fast_servo_o(),
    .sup_low_res_o, .adc_hires_o, .dac_gain_hi_o, .dac_noninv_o, .track_en_o(trk));
  cstc_dcdc_model #(.RISE_CYC(8)) i_cstc_dcdc_model (.sys_clk_i, .enable_i(enable_o),
    .dac_connect_i(dac_connect_o), .rise_done_o(rise_done_i), .off_seq_done_o(off_seq_done_i),
    .target_reached_o(target_reached_i));
  initial begin
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] p, input logic [15:0] d);
    @(negedge sys_clk_i);
    page_i = p;
    cfg_wdata_i = d;
    cfg_wr_i = 1'b1;
    @(negedge sys_clk_i);
    cfg_wr_i = 1'b0;
  endtask
  task automatic rd(input logic [2:0] p);
    @(negedge sys_clk_i);
    page_i = p;
    repeat (2) @(negedge sys_clk_i);
    rd_val = cfg_rdata_o;
  endtask
  // Enable timing depends on ramp and fall allowance, so wait with a bound
  task automatic wait_en(input logic [7:0] exp);
    int n;
    n = 0;
    while (enable_o !== exp && n < 400) begin
      @(negedge sys_clk_i);
      n++;
    end
    check({8'h00, enable_o}, {8'h00, exp});
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic t_reset();
    repeat (20) @(negedge sys_clk_i);
    check({enable_oe_o, fast_pulldown_o}, 16'hffff);
    srst_i = 1'b0;
    rd(3'h5);
    check(rd_val, 16'h0000);
    $display("reset test done");
  endtask
  task automatic t_regs();
    logic [15:0] d;
    for (int p = 0; p < 8; p++) wr(p[2:0], 16'h3e00 ^ {5'h00, p[2:0], 5'h00, p[2:0]});
    for (int p = 0; p < 8; p++) begin
      d = 16'h3e00 ^ {5'h00, p[2:0], 5'h00, p[2:0]};
      rd(p[2:0]);
      check(rd_val, d & 16'hcfff);
      check({13'h0000, sup_low_res_o[p], dac_gain_hi_o[p], dac_noninv_o[p]},
        {13'h0000, d[10], d[1:0]});
      check({15'h0000, adc_hires_o[p]}, {15'h0000, d[9] & p[0]});
    end
    $display("register test done");
  endtask
  task automatic t_run();
    for (int p = 0; p < 8; p++) wr(p[2:0], 16'h0000);
    wr(3'h0, 16'h000c);
    wr(3'h4, 16'h000c);
    wr(3'h1, 16'h0100);
    dac_code_written_i = 8'hff;
    run_input_a_i = 1'b1;
    wait_en(8'hfd);
    check({8'h00, wpu}, 16'h0001);
    check({8'h00, enable_oe_o}, 16'h0002);
    // Model ramp is 8 cycles, then connect and target take two more
    repeat (15) @(negedge sys_clk_i);
    check({dac_connect_o, servo_o}, 16'hfd00);
    run_input_a_i = 1'b0;
    wait_en(8'h00);
    check({8'h00, wpd}, 16'h0001);
    run_input_b_i = 1'b1;
    wait_en(8'h02);
    run_input_a_i = 1'b1;
    wait_en(8'hff);
    chan_fault_i = 8'h01;
    wait_en(8'hfe);
    check({14'h0000, wpd[0], fast_pulldown_o[0]}, 16'h0001);
    chan_fault_i = 8'h00;
    run_input_a_i = 1'b0;
    run_input_b_i = 1'b0;
    $display("run select test done");
  endtask
  task automatic t_track();
    wr(3'h1, 16'h0000);
    wr(3'h2, 16'h8000);
    wr(3'h3, 16'hc000);
    // Let the group finish its fall allowance from the previous test
    repeat (250) @(negedge sys_clk_i);
    run_input_a_i = 1'b1;
    wait_en(8'h0c);
    wait_en(8'hff);
    check({8'h00, trk}, 16'h000c);
    chan_fault_i = 8'h01;
    wait_en(8'h0c);
    wait_en(8'h00);
    check({14'h0000, uv_mask_o[3:2]}, 16'h0003);
    chan_fault_i = 8'h00;
    wait_en(8'hff);
    timebase_low_i = 1'b1;
    wait_en(8'h0c);
    wait_en(8'h00);
    timebase_low_i = 1'b0;
    run_input_a_i = 1'b0;
    $display("tracking test done");
  endtask
  // About 800 cycles are needed; the ceiling leaves generous room
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      close_out();
    end
  end
  initial begin
    t_reset();
    t_regs();
    t_run();
    t_track();
    close_out();
  end
endmodule // cstc_channel_seq_tb
`default_nettype wire
